// >>> common/ubd_pkg.sv
// Constants, encodings and state type of the endpoint buffer-descriptor logic.
// Assumes one clock domain and a half-word wide packet memory of 256 entries.
package ubd_pkg;
    localparam logic [1:0] EP_BULK = 2'h0;
    localparam logic [1:0] EP_CONTROL = 2'h1;
    localparam logic [1:0] EP_ISO = 2'h2;
    localparam logic [1:0] EP_INTERRUPT = 2'h3;

    localparam logic [1:0] STAT_DISABLED = 2'h0;
    localparam logic [1:0] STAT_STALL = 2'h1;
    localparam logic [1:0] STAT_NAK = 2'h2;
    localparam logic [1:0] STAT_VALID = 2'h3;

    localparam logic [1:0] PID_IN = 2'h0;
    localparam logic [1:0] PID_OUT = 2'h1;
    localparam logic [1:0] PID_SETUP = 2'h2;

    localparam logic [2:0] RESP_IGNORE = 3'h0;
    localparam logic [2:0] RESP_STALL = 3'h1;
    localparam logic [2:0] RESP_NAK = 3'h2;
    localparam logic [2:0] RESP_DATA = 3'h3;
    localparam logic [2:0] RESP_ACCEPT = 3'h4;
    localparam logic [2:0] RESP_ACK = 3'h5;

    localparam logic [15:0] OFF_TX_ADDR = 16'h0000;
    localparam logic [15:0] OFF_TX_COUNT = 16'h0002;
    localparam logic [15:0] OFF_RX_ADDR = 16'h0004;
    localparam logic [15:0] OFF_RX_COUNT = 16'h0006;
    localparam int ENTRY_SHIFT = 3;
    localparam int BUS_WORD_SHIFT = 2;

    localparam int COUNT_W = 10;
    localparam int SIZE_LO = 10;
    localparam int SIZE_HI = 14;
    localparam int GRANULE_BIT = 15;
    localparam int LARGE_SHIFT = 5;
    localparam logic [9:0] COUNT_MAX = 10'h3ff;

    localparam int PMA_AW = 8;
    localparam int PMA_DEPTH = 256;
    localparam int BUS_AW = 10;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_FETCH_A = 6'h02,
        ST_FETCH_C = 6'h04,
        ST_DECIDE = 6'h08,
        ST_RX = 6'h10,
        ST_WB = 6'h20
    } ubd_state_type;
endpackage

// >>> rtl/ubd_descriptor_engine.sv
// Endpoint buffer-descriptor engine: decodes endpoint settings, fetches
// descriptor words, stores received bytes and writes the count back.
// Assumes token, data and handshake strobes come from logic on clk.
`timescale 1ns/1ps
module ubd_descriptor_engine
    import ubd_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Software access to packet memory
    input wire logic bus_sel,
    input wire logic bus_write,
    input wire logic [BUS_AW-1:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    output logic [15:0] bus_rdata,
    output logic bus_ready,
    // Descriptor table base, bits 15:3
    input wire logic [15:3] descriptor_table_base,
    // Token from the serial engine
    input wire logic tok_valid,
    input wire logic [1:0] tok_pid,
    input wire logic [2:0] tok_ep,
    input wire logic [1:0] endpoint_category,
    input wire logic endpoint_option_bit,
    input wire logic [1:0] tx_state,
    input wire logic [1:0] rx_state,
    input wire logic buf_sel,
    // Decision
    output logic resp_valid,
    output logic [2:0] resp_code,
    output logic [15:0] buf_start,
    output logic [9:0] buf_bytes,
    output logic [10:0] buf_limit,
    output logic double_buffer_enable,
    output logic status_out_expect,
    // Receive stream
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_end,
    output logic rx_done,
    output logic rx_ok,
    output logic rx_overflow,
    // Transmit completion
    input wire logic in_ack,
    output logic tx_state_to_nak
);
    typedef struct packed {
        ubd_state_type st;
        logic [1:0] pid;
        logic [1:0] cat;
        logic [1:0] ts;
        logic [1:0] rs;
        logic dbl;
        logic sout;
        logic [15:0] word_base;
        logic [15:0] addr;
        logic [15:0] cntw;
        logic [10:0] limit;
        logic [9:0] rcount;
        logic [7:0] lowb;
        logic ovf;
        logic resp_valid;
        logic [2:0] resp_code;
        logic [15:0] buf_start;
        logic [9:0] buf_bytes;
        logic [10:0] buf_limit;
        logic rx_done;
        logic rx_ok;
        logic rx_overflow;
        logic tx_nak;
    } ubd_core_type;

    ubd_core_type q;
    ubd_core_type next_q;

    logic eng_req;
    logic eng_we;
    logic [PMA_AW-1:0] eng_idx;
    logic [15:0] eng_wdata;
    logic [15:0] eng_rdata;

    function automatic logic [PMA_AW-1:0] hw_index(input logic [15:0] byte_addr);
        hw_index = byte_addr[PMA_AW:1];
    endfunction

    function automatic logic [10:0] alloc_size(input logic [15:0] w);
        logic [4:0] nb;
        nb = w[SIZE_HI:SIZE_LO];
        if (w[GRANULE_BIT]) begin
            alloc_size = 11'({1'b0, nb} + 6'h01) << LARGE_SHIFT;
        end else begin
            alloc_size = {5'h00, nb, 1'b0};
        end
    endfunction

    ubd_pkt_mem u_mem (
        .clk(clk),
        .resetn(resetn),
        .eng_req(eng_req),
        .eng_we(eng_we),
        .eng_idx(eng_idx),
        .eng_wdata(eng_wdata),
        .eng_rdata(eng_rdata),
        .bus_sel(bus_sel),
        .bus_write(bus_write),
        .bus_addr(bus_addr),
        .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata),
        .bus_ready(bus_ready)
    );

    always_comb begin
        logic use_hi;
        logic [15:0] entry;
        logic [15:0] waddr;
        use_hi = 1'b0;
        entry = '0;
        waddr = '0;
        next_q = q;
        next_q.resp_valid = 1'b0;
        next_q.rx_done = 1'b0;
        next_q.tx_nak = 1'b0;
        eng_req = 1'b0;
        eng_we = 1'b0;
        eng_idx = '0;
        eng_wdata = '0;
        // A good IN handshake on a non-isochronous, single-buffered endpoint hands the buffer back to software
        if (in_ack && q.cat != EP_ISO && !q.dbl) begin
            next_q.tx_nak = 1'b1;
        end
        case (q.st)
            ST_IDLE: begin
                if (tok_valid) begin
                    next_q.pid = tok_pid;
                    next_q.cat = endpoint_category;
                    next_q.ts = tx_state;
                    next_q.rs = rx_state;
                    next_q.dbl = endpoint_category == EP_BULK
                        && endpoint_option_bit;
                    next_q.sout = endpoint_category == EP_CONTROL
                        && endpoint_option_bit;
                    // Buffer 1 lives in the receive words, buffer 0 in the transmit words
                    if ((endpoint_category == EP_BULK && endpoint_option_bit)
                        || endpoint_category == EP_ISO) begin
                        use_hi = buf_sel;
                    end else begin
                        use_hi = tok_pid != PID_IN;
                    end
                    entry = {descriptor_table_base, 3'h0}
                        + 16'({13'h0000, tok_ep} << ENTRY_SHIFT);
                    next_q.word_base = entry + (use_hi ? OFF_RX_ADDR : OFF_TX_ADDR);
                    next_q.st = ST_FETCH_A;
                end
            end
            ST_FETCH_A: begin
                eng_req = 1'b1;
                eng_idx = hw_index(q.word_base);
                next_q.st = ST_FETCH_C;
            end
            ST_FETCH_C: begin
                next_q.addr = {eng_rdata[15:1], 1'b0};
                eng_req = 1'b1;
                eng_idx = hw_index(q.word_base + OFF_TX_COUNT);
                next_q.st = ST_DECIDE;
            end
            ST_DECIDE: begin
                next_q.cntw = eng_rdata;
                next_q.limit = alloc_size(eng_rdata);
                next_q.rcount = '0;
                next_q.ovf = 1'b0;
                next_q.resp_valid = 1'b1;
                next_q.buf_start = q.addr;
                next_q.buf_bytes = eng_rdata[COUNT_W-1:0];
                next_q.buf_limit = alloc_size(eng_rdata);
                next_q.st = ST_IDLE;
                if (q.pid == PID_IN) begin
                    case (q.ts)
                        STAT_DISABLED: next_q.resp_code = RESP_IGNORE;
                        STAT_STALL: next_q.resp_code = RESP_STALL;
                        STAT_NAK: next_q.resp_code = RESP_NAK;
                        default: next_q.resp_code = RESP_DATA;
                    endcase
                end else if (q.pid == PID_SETUP) begin
                    // Setup is never refused by handshake; a NAK state stays silent
                    if (q.cat != EP_CONTROL || q.rs == STAT_DISABLED
                        || q.rs == STAT_NAK) begin
                        next_q.resp_code = RESP_IGNORE;
                    end else begin
                        next_q.resp_code = RESP_ACCEPT;
                        next_q.st = ST_RX;
                    end
                end else begin
                    case (q.rs)
                        STAT_DISABLED: next_q.resp_code = RESP_IGNORE;
                        STAT_STALL: next_q.resp_code = RESP_STALL;
                        STAT_NAK: next_q.resp_code = RESP_NAK;
                        default: begin
                            next_q.resp_code = RESP_ACCEPT;
                            next_q.st = ST_RX;
                        end
                    endcase
                end
            end
            ST_RX: begin
                if (rx_valid) begin
                    if (11'(q.rcount) >= q.limit) begin
                        next_q.ovf = 1'b1;
                    end else if (q.rcount[0]) begin
                        waddr = q.addr + 16'({q.rcount[9:1], 1'b0});
                        eng_req = 1'b1;
                        eng_we = 1'b1;
                        eng_idx = hw_index(waddr);
                        eng_wdata = {rx_data, q.lowb};
                    end else begin
                        next_q.lowb = rx_data;
                    end
                    if (q.rcount != COUNT_MAX) begin
                        next_q.rcount = q.rcount + 10'h001;
                    end
                end else if (rx_end) begin
                    // An odd last byte is flushed alone, high half zero
                    if (q.rcount[0] && !q.ovf) begin
                        waddr = q.addr + 16'({q.rcount[9:1], 1'b0});
                        eng_req = 1'b1;
                        eng_we = 1'b1;
                        eng_idx = hw_index(waddr);
                        eng_wdata = {8'h00, q.lowb};
                    end
                    next_q.st = ST_WB;
                end
            end
            ST_WB: begin
                eng_req = 1'b1;
                eng_we = 1'b1;
                eng_idx = hw_index(q.word_base + OFF_TX_COUNT);
                eng_wdata = {q.cntw[15:COUNT_W], q.rcount};
                next_q.rx_done = 1'b1;
                next_q.rx_overflow = q.ovf;
                next_q.rx_ok = !q.ovf
                    && !(q.sout && q.pid == PID_OUT && q.rcount != '0);
                next_q.resp_valid = !q.ovf;
                next_q.resp_code = (q.sout && q.pid == PID_OUT && q.rcount != '0)
                    ? RESP_STALL : RESP_ACK;
                next_q.st = ST_IDLE;
            end
            default: begin
                next_q.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
            q.st <= ST_IDLE;
        end else begin
            q <= next_q;
        end
    end

    assign resp_valid = q.resp_valid;
    assign resp_code = q.resp_code;
    assign buf_start = q.buf_start;
    assign buf_bytes = q.buf_bytes;
    assign buf_limit = q.buf_limit;
    assign double_buffer_enable = q.dbl;
    assign status_out_expect = q.sout;
    assign rx_done = q.rx_done;
    assign rx_ok = q.rx_ok;
    assign rx_overflow = q.rx_overflow;
    assign tx_state_to_nak = q.tx_nak;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    a_tx_off_quiet: assert property (
        q.st == ST_DECIDE && q.pid == PID_IN && q.ts == STAT_DISABLED
        |=> resp_valid && resp_code == RESP_IGNORE)
        else $error("disabled endpoint answered an IN");
    a_tx_stall_ans: assert property (
        q.st == ST_DECIDE && q.pid == PID_IN && q.ts == STAT_STALL
        |=> resp_valid && resp_code == RESP_STALL)
        else $error("stalled endpoint did not stall");
    a_tx_nak_ans: assert property (
        q.st == ST_DECIDE && q.pid == PID_IN && q.ts == STAT_NAK
        |=> resp_valid && resp_code == RESP_NAK)
        else $error("nak endpoint did not nak");
    a_tx_valid_data: assert property (
        q.st == ST_DECIDE && q.pid == PID_IN && q.ts == STAT_VALID
        |=> resp_valid && resp_code == RESP_DATA && q.st == ST_IDLE)
        else $error("valid endpoint sent no data");
    a_fetch_four: assert property (
        q.st == ST_IDLE && tok_valid |-> ##4 resp_valid)
        else $error("descriptor decision not four cycles after token");
    a_start_even: assert property (
        resp_valid && resp_code == RESP_DATA |-> buf_start[0] == 1'b0)
        else $error("buffer start not half-word aligned");
    a_wb_keep_size: assert property (
        q.st == ST_WB |-> eng_we && eng_wdata[15:COUNT_W] == q.cntw[15:COUNT_W]
        ##1 rx_done && q.st == ST_IDLE)
        else $error("count write-back disturbed size fields");
    a_ovf_no_write: assert property (
        q.st == ST_RX && q.ovf |-> !eng_we || rx_end)
        else $error("write past buffer allocation");
    a_ovf_not_ok: assert property (
        rx_done && rx_overflow |-> !rx_ok && !resp_valid)
        else $error("overflowed reception reported correct");
    a_in_to_nak: assert property (
        in_ack && q.cat != EP_ISO && !q.dbl |=> tx_state_to_nak)
        else $error("transmit state not set to nak after IN");
    // Receive side decode; an accepted OUT must open the byte stream
    a_rx_off_quiet: assert property (
        q.st == ST_DECIDE && q.pid == PID_OUT && q.rs == STAT_DISABLED
        |=> resp_valid && resp_code == RESP_IGNORE && q.st == ST_IDLE)
        else $error("disabled endpoint answered an OUT");
    a_rx_stall_ans: assert property (
        q.st == ST_DECIDE && q.pid == PID_OUT && q.rs == STAT_STALL
        |=> resp_valid && resp_code == RESP_STALL && q.st == ST_IDLE)
        else $error("stalled endpoint did not stall an OUT");
    a_rx_nak_ans: assert property (
        q.st == ST_DECIDE && q.pid == PID_OUT && q.rs == STAT_NAK
        |=> resp_valid && resp_code == RESP_NAK && q.st == ST_IDLE)
        else $error("nak endpoint did not nak an OUT");
    a_rx_accept: assert property (
        q.st == ST_DECIDE && q.pid == PID_OUT && q.rs == STAT_VALID
        |=> resp_valid && resp_code == RESP_ACCEPT && q.st == ST_RX)
        else $error("valid endpoint did not accept an OUT");
    a_setup_ctrl_only: assert property (
        q.st == ST_DECIDE && q.pid == PID_SETUP && q.cat != EP_CONTROL
        |=> resp_code == RESP_IGNORE && q.st == ST_IDLE)
        else $error("setup taken by a non-control endpoint");
    a_rx_end_wb: assert property (
        q.st == ST_RX && rx_end && !rx_valid
        |=> q.st == ST_WB)
        else $error("end of packet did not start count write-back");
endmodule

// >>> rtl/ubd_pkt_mem.sv
// Half-word packet memory with an engine port and a software bus port.
// Assumes the bus master holds its request until the ready pulse.
`timescale 1ns/1ps
module ubd_pkt_mem
    import ubd_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Engine port, always served
    input wire logic eng_req,
    input wire logic eng_we,
    input wire logic [PMA_AW-1:0] eng_idx,
    input wire logic [15:0] eng_wdata,
    output logic [15:0] eng_rdata,
    // Software port, served in free cycles
    input wire logic bus_sel,
    input wire logic bus_write,
    input wire logic [BUS_AW-1:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    output logic [15:0] bus_rdata,
    output logic bus_ready
);
    typedef struct packed {
        logic [15:0] eng_rdata;
        logic [15:0] bus_rdata;
        logic bus_ready;
    } ubd_mem_type;

    ubd_mem_type q;
    ubd_mem_type next_q;
    logic [15:0] mem [PMA_DEPTH];
    logic bus_go;
    logic [PMA_AW-1:0] bus_idx;

    // Engine wins so a reception in flight never loses a byte
    assign bus_go = bus_sel && !eng_req && !q.bus_ready;
    assign bus_idx = bus_addr[BUS_WORD_SHIFT +: PMA_AW];

    always_comb begin
        next_q = q;
        next_q.bus_ready = bus_go;
        if (eng_req) begin
            next_q.eng_rdata = mem[eng_idx];
        end
        if (bus_go && !bus_write) begin
            next_q.bus_rdata = mem[bus_idx];
        end
    end

    always_ff @(posedge clk) begin
        if (eng_req && eng_we) begin
            mem[eng_idx] <= eng_wdata;
        end else if (bus_go && bus_write) begin
            mem[bus_idx] <= bus_wdata;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign eng_rdata = q.eng_rdata;
    assign bus_rdata = q.bus_rdata;
    assign bus_ready = q.bus_ready;
endmodule

// >>> sim/ubd_host_model.sv
// Serial-engine stand-in: tokens, received bytes and IN acknowledges.
// Assumes its tasks are called just after a falling edge of clk.
`timescale 1ns/1ps
module ubd_host_model (
    // Clock
    input wire logic clk,
    // Toward the engine
    output logic tok_valid,
    output logic [1:0] tok_pid,
    output logic [2:0] tok_ep,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_end,
    output logic in_ack
);
    initial begin
        tok_valid = 1'b0;
        tok_pid = 2'h0;
        tok_ep = 3'h0;
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_end = 1'b0;
        in_ack = 1'b0;
    end
    // Released fields flip so a stale value never passes for a live one
    task automatic token(input logic [1:0] pid, input logic [2:0] ep);
        tok_pid = pid;
        tok_ep = ep;
        tok_valid = 1'b1;
        @(negedge clk);
        tok_valid = 1'b0;
        tok_pid = ~pid;
        tok_ep = ~ep;
    endtask
    // Gap adds idle cycles between bytes to play a slow host
    task automatic send(input int n, input int gap, input logic [7:0] b0);
        for (int i = 0; i < n; i++) begin
            rx_data = b0 + 8'(i);
            rx_valid = 1'b1;
            @(negedge clk);
            rx_valid = 1'b0;
            rx_data = ~rx_data;
            repeat (gap) @(negedge clk);
        end
        rx_end = 1'b1;
        @(negedge clk);
        rx_end = 1'b0;
    endtask
    task automatic ack;
        in_ack = 1'b1;
        @(negedge clk);
        in_ack = 1'b0;
    endtask
endmodule

// >>> sim/usb_endpoint_buffer_descriptors_tb.sv
// Self-checking bench for the descriptor engine; the bench plays software.
// Assumes the host model drives tokens and bytes; table base is local 0x040.
`timescale 1ns/1ps
module usb_endpoint_buffer_descriptors_tb
    import ubd_pkg::*;
;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic bus_sel = 1'b0;
    logic bus_write = 1'b0;
    logic [9:0] bus_addr = 10'h000;
    logic [15:0] bus_wdata = 16'h0000;
    logic [15:3] descriptor_table_base = 13'h0008;
    logic [1:0] endpoint_category = 2'h0;
    logic endpoint_option_bit = 1'b0;
    logic [1:0] tx_state = 2'h0;
    logic [1:0] rx_state = 2'h0;
    logic buf_sel = 1'b0;
    logic tok_valid, rx_valid, rx_end, in_ack, bus_ready, resp_valid;
    logic double_buffer_enable, status_out_expect;
    logic rx_done, rx_ok, rx_overflow, tx_state_to_nak;
    logic [1:0] tok_pid;
    logic [2:0] tok_ep, resp_code;
    logic [7:0] rx_data;
    logic [15:0] bus_rdata, buf_start;
    logic [9:0] buf_bytes;
    logic [10:0] buf_limit;
    int n_mismatch = 0;
    int check_count = 0;

    always #12.5 clk = ~clk;

    ubd_descriptor_engine u_dut (
        .clk, .resetn, .bus_sel, .bus_write, .bus_addr, .bus_wdata, .bus_rdata,
        .bus_ready, .descriptor_table_base, .tok_valid, .tok_pid, .tok_ep,
        .endpoint_category, .endpoint_option_bit, .tx_state, .rx_state, .buf_sel,
        .resp_valid, .resp_code, .buf_start, .buf_bytes, .buf_limit,
        .double_buffer_enable, .status_out_expect, .rx_valid, .rx_data, .rx_end,
        .rx_done, .rx_ok, .rx_overflow, .in_ack, .tx_state_to_nak
    );
    ubd_host_model u_host (
        .clk, .tok_valid, .tok_pid, .tok_ep, .rx_valid, .rx_data, .rx_end, .in_ack
    );

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Request held until the edge that samples ready, then released
    task automatic bus(input logic wr, input logic [8:0] la, input logic [15:0] wd,
                       output logic [15:0] rd);
        int k;
        k = 0;
        bus_write = wr;
        bus_addr = {la, 1'b0};
        bus_wdata = wd;
        bus_sel = 1'b1;
        do begin
            @(negedge clk);
            k++;
        end while (bus_ready !== 1'b1 && k < 60);
        rd = bus_rdata;
        chk(16'(bus_ready), 16'h0001);
        @(negedge clk);
        bus_sel = 1'b0;
        bus_addr = ~bus_addr;
        bus_wdata = ~bus_wdata;
        @(negedge clk);
    endtask
    task automatic wr(input logic [8:0] la, input logic [15:0] d);
        logic [15:0] x;
        bus(1'b1, la, d, x);
    endtask
    task automatic rd(input logic [8:0] la, input logic [15:0] e);
        logic [15:0] x;
        bus(1'b0, la, 16'h0000, x);
        chk(x, e);
    endtask
    task automatic desc(input logic [2:0] ep, input logic [15:0] ta, tc, ra, rc);
        logic [8:0] b;
        b = 9'h040 + {3'h0, ep, 3'h0};
        wr(b, ta);
        wr(b + 9'h002, tc);
        wr(b + 9'h004, ra);
        wr(b + 9'h006, rc);
    endtask
    task automatic cfg(input logic [1:0] cat, input logic opt, input logic [1:0] txs, rxs,
                       input logic bs);
        endpoint_category = cat;
        endpoint_option_bit = opt;
        tx_state = txs;
        rx_state = rxs;
        buf_sel = bs;
        @(negedge clk);
    endtask
    // Code 7 means the handshake code is not judged
    task automatic tok(input logic [1:0] pid, input logic [2:0] ep, input logic [2:0] code);
        u_host.token(pid, ep);
        // The decision pulse stands only in the cycle after the third edge
        repeat (3) @(negedge clk);
        chk(16'(resp_valid), 16'h0001);
        if (code != 3'h7)
            chk(16'(resp_code), 16'(code));
    endtask
    task automatic fin(input logic ok, input logic ovf, input logic [2:0] code);
        repeat (1) @(negedge clk);
        chk(16'(rx_done), 16'h0001);
        chk(16'(rx_ok), 16'(ok));
        chk(16'(rx_overflow), 16'(ovf));
        if (code != 3'h7)
            chk(16'(resp_valid), 16'(!ovf));
        if (!ovf && code != 3'h7)
            chk(16'(resp_code), 16'(code));
    endtask

    task automatic t_tx;
        logic [2:0] c [4];
        c = '{RESP_IGNORE, RESP_STALL, RESP_NAK, RESP_DATA};
        desc(3'h3, 16'h0100, 16'hfc05, 16'h0140, 16'h8403);
        rd(9'h05a, 16'hfc05);
        for (int s = 0; s < 4; s++) begin
            cfg(EP_INTERRUPT, 1'b0, 2'(s), STAT_VALID, 1'b0);
            tok(PID_IN, 3'h3, c[s]);
        end
        chk(buf_start, 16'h0100);
        chk(16'(buf_bytes), 16'h0005);
    endtask
    task automatic t_kind;
        for (int k = 0; k < 4; k++) begin
            cfg(2'(k), 1'b1, STAT_DISABLED, STAT_VALID, 1'b0);
            tok(PID_IN, 3'h3, (k == 0) ? 3'h7 : RESP_IGNORE);
            chk(16'(double_buffer_enable), 16'(k == 0));
            chk(16'(status_out_expect), 16'(k == 1));
        end
    endtask
    task automatic t_dbl;
        for (int k = 0; k < 2; k++) begin
            cfg(k ? EP_ISO : EP_BULK, 1'b1, STAT_VALID, STAT_VALID, 1'b1);
            tok(PID_IN, 3'h3, 3'h7);
            chk(buf_start, 16'h0140);
            chk(16'(buf_bytes), 16'h0003);
        end
    endtask
    task automatic t_ack;
        int n;
        for (int k = 0; k < 3; k++) begin
            n = 0;
            cfg((k == 1) ? EP_ISO : EP_BULK, k == 2, STAT_VALID, STAT_VALID, 1'b0);
            tok(PID_IN, 3'h3, 3'h7);
            u_host.ack();
            repeat (2) begin
                n += int'(tx_state_to_nak === 1'b1);
                @(negedge clk);
            end
            chk(16'(n), 16'(k == 0));
        end
    endtask
    task automatic t_rx;
        desc(3'h5, 16'h0180, 16'h0800, 16'h0140, 16'h0c00);
        wr(9'h146, 16'hdead);
        cfg(EP_BULK, 1'b0, STAT_NAK, STAT_VALID, 1'b0);
        tok(PID_OUT, 3'h5, RESP_ACCEPT);
        chk(buf_start, 16'h0140);
        chk(16'(buf_limit), 16'h0006);
        fork
            begin
                u_host.send(3, 0, 8'ha0);
                fin(1'b1, 1'b0, RESP_ACK);
            end
            rd(9'h146, 16'hdead);
        join
        rd(9'h140, 16'ha1a0);
        rd(9'h142, 16'h00a2);
        rd(9'h06e, 16'h0c03);
        tok(PID_OUT, 3'h5, RESP_ACCEPT);
        u_host.send(8, 1, 8'hb0);
        fin(1'b0, 1'b1, 3'h0);
        rd(9'h144, 16'hb5b4);
        rd(9'h146, 16'hdead);
    endtask
    task automatic t_mode;
        logic [2:0] c [3];
        c = '{RESP_IGNORE, RESP_STALL, RESP_NAK};
        for (int s = 0; s < 3; s++) begin
            cfg(EP_BULK, 1'b0, STAT_NAK, 2'(s), 1'b0);
            tok(PID_OUT, 3'h5, c[s]);
        end
        cfg(EP_CONTROL, 1'b0, STAT_NAK, STAT_NAK, 1'b0);
        tok(PID_SETUP, 3'h5, RESP_IGNORE);
        wr(9'h06e, 16'hb800);
        cfg(EP_CONTROL, 1'b1, STAT_NAK, STAT_VALID, 1'b0);
        tok(PID_OUT, 3'h5, RESP_ACCEPT);
        chk(16'(buf_limit), 16'h01e0);
        u_host.send(1, 0, 8'h11);
        fin(1'b0, 1'b0, RESP_STALL);
        cfg(EP_ISO, 1'b0, STAT_VALID, STAT_VALID, 1'b0);
        tok(PID_OUT, 3'h5, RESP_ACCEPT);
        chk(buf_start, 16'h0180);
        chk(16'(buf_limit), 16'h0004);
        u_host.send(2, 0, 8'h5a);
        fin(1'b1, 1'b0, 3'h7);
        rd(9'h180, 16'h5b5a);
        rd(9'h06a, 16'h0802);
        cfg(EP_BULK, 1'b0, STAT_NAK, STAT_VALID, 1'b0);
        tok(PID_SETUP, 3'h5, RESP_IGNORE);
        cfg(EP_CONTROL, 1'b0, STAT_NAK, STAT_STALL, 1'b0);
        tok(PID_SETUP, 3'h5, RESP_ACCEPT);
        u_host.send(2, 0, 8'h3c);
        fin(1'b1, 1'b0, RESP_ACK);
        rd(9'h140, 16'h3d3c);
        rd(9'h06e, 16'hb802);
    endtask

    task automatic summarize;
        $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        repeat (8) @(negedge clk);
        resetn = 1'b1;
        @(negedge clk);
        t_tx();
        t_kind();
        t_dbl();
        t_ack();
        t_rx();
        t_mode();
        summarize();
    end
    // Whole run needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        $display("Watchdog expired at %0t", $time);
        summarize();
    end
endmodule
